/* logic/float_math_pkg.sv */
// Constants and types for the float-mode configuration block
package float_math_pkg;
    // Register offsets
    localparam logic [7:0] BKG_LIMIT_ADDR   = 8'h1c;
    localparam logic [7:0] LED_CFG_A_ADDR   = 8'h3e;
    localparam logic [7:0] LED_CFG_B_ADDR   = 8'h3f;
    localparam logic [7:0] MATH_CTRL_ADDR   = 8'h58;
    localparam logic [7:0] FLOAT_ENABLE_B_ADDR    = 8'h59;
    localparam logic [7:0] FLOAT_ENABLE_A_ADDR    = 8'h5e;
    localparam logic [7:0] BKG_CNT_ADDR     = 8'h7f;
    // Field positions
    localparam int LED_SEL_LSB      = 14;
    localparam int LED_WIDTH_LSB    = 8;
    localparam int LED_OFFSET_LSB   = 0;
    localparam int MATH12_A_LSB     = 1;
    localparam int MATH12_B_LSB     = 5;
    localparam int INT_BUF_BIT      = 7;
    localparam int MATH34_A_LSB     = 8;
    localparam int MATH34_B_LSB     = 10;
    localparam int FLT_EN_LSB       = 13;
    // Reset values, writable masks and the enable-on code
    localparam logic [15:0] LED_CFG_RESET   = 16'h0320;
    localparam logic [15:0] LED_CFG_MASK    = 16'hdfff;
    localparam logic [15:0] MATH_RESET      = 16'h0000;
    localparam logic [15:0] MATH_MASK       = 16'h0fe6;
    localparam logic [13:0] BKG_LIMIT_RESET = 14'h0000;
    localparam logic [1:0]  FLT_EN_RESET    = 2'h0;
    localparam logic [1:0]  FLT_EN_ON       = 2'h3;
    // Timing
    localparam int CLK_PERIOD_NS    = 10;
    localparam int STEP_US          = 1;
    localparam int STEP_CYCLES      = STEP_US * 1000 / CLK_PERIOD_NS;
    localparam logic [6:0] STEP_LAST = 7'(STEP_CYCLES - 1);

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_DELAY,
        SEQ_FIRE,
        SEQ_WAIT
    } seq_state_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } reg_req_t;

    typedef struct packed {
        logic        start;
        logic        slot_b;
        logic        pulse_req;
        logic        slot_end;
    } seq_ctl_t;

    typedef struct packed {
        seq_state_t  st;
        logic        slot_b;
        logic [13:0] limit;
        logic [15:0] led_a;
        logic [15:0] led_b;
        logic [15:0] math;
        logic [1:0]  en_a;
        logic [1:0]  en_b;
        logic [6:0]  tick;
        logic [7:0]  ucnt;
        logic [1:0]  idx;
        logic [15:0] bkg_cnt;
        logic [15:0] rd;
        logic [2:0]  led;
        logic        smp_v;
        logic        smp_sub;
    } state_t;
endpackage : float_math_pkg

/* logic/float_mode_pulse_math_config.sv */
// Float-mode register bank, LED pulse timer and sample sign logic
`timescale 1ns/1ps
`default_nettype none

module float_mode_pulse_math_config (
    // Clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_nrst,
    // Register port
    input  wire float_math_pkg::reg_req_t i_reg,
    output logic [15:0]                   o_rd_data,
    // Sequencer control
    input  wire float_math_pkg::seq_ctl_t i_seq,
    // Samples
    input  wire logic                     i_sample_valid,
    input  wire logic [13:0]              i_adc_data,
    // Results
    output logic [2:0]                    o_led_drive,
    output logic                          o_sample_valid,
    output logic                          o_sample_subtract,
    output logic                          o_integrator_buffer,
    output logic                          o_busy,
    output logic [15:0]                   o_bkg_exceed_count
);
    float_math_pkg::state_t s_ff;
    float_math_pkg::state_t nxt_s;

    // Sign for a sample position within a four-sample group
    function automatic logic sign_of(input logic [15:0] math,
                                     input logic sb,
                                     input logic [1:0] idx);
        logic [1:0] code;
        code = 2'h0;
        if (idx[1] == 1'b0) begin
            code = sb ? math[float_math_pkg::MATH12_B_LSB +: 2]
                      : math[float_math_pkg::MATH12_A_LSB +: 2];
        end
        else begin
            code = sb ? math[float_math_pkg::MATH34_B_LSB +: 2]
                      : math[float_math_pkg::MATH34_A_LSB +: 2];
        end
        return idx[0] ? code[0] : code[1];
    endfunction : sign_of

    // One-hot LED drive from a two-bit choice, all off for choice zero
    function automatic logic [2:0] led_of(input logic [1:0] sel);
        logic [2:0] v;
        v = 3'h0;
        if (sel != 2'h0) begin
            v[sel - 2'h1] = 1'b1;
        end
        return v;
    endfunction : led_of

    logic [15:0] cfg;
    logic        us_tick;
    logic        slot_on;

    always_comb begin
        nxt_s   = s_ff;
        cfg     = s_ff.slot_b ? s_ff.led_b : s_ff.led_a;
        us_tick = 1'b0;
        slot_on = 1'b0;
        nxt_s.smp_v = 1'b0;
        if (s_ff.st != float_math_pkg::SEQ_IDLE) begin
            if (s_ff.tick == float_math_pkg::STEP_LAST) begin
                nxt_s.tick = 7'h0;
                us_tick    = 1'b1;
            end else begin
                nxt_s.tick = s_ff.tick + 7'h1;
            end
        end
        case (s_ff.st)
            float_math_pkg::SEQ_DELAY: begin
                if (s_ff.ucnt == 8'h0) begin
                    nxt_s.ucnt = 8'(cfg[float_math_pkg::LED_WIDTH_LSB +: 5]);
                    nxt_s.tick = 7'h0;
                    if (cfg[float_math_pkg::LED_WIDTH_LSB +: 5] == 5'h0) begin
                        nxt_s.st = float_math_pkg::SEQ_WAIT;
                    end else begin
                        nxt_s.st  = float_math_pkg::SEQ_FIRE;
                        nxt_s.led = led_of(cfg[float_math_pkg::LED_SEL_LSB +: 2]);
                    end
                end else if (us_tick) begin
                    nxt_s.ucnt = s_ff.ucnt - 8'h1;
                end
            end
            float_math_pkg::SEQ_FIRE: begin
                if (us_tick) begin
                    nxt_s.ucnt = s_ff.ucnt - 8'h1;
                    if (s_ff.ucnt == 8'h1) begin
                        nxt_s.st  = float_math_pkg::SEQ_WAIT;
                        nxt_s.led = 3'h0;
                    end
                end
            end
            float_math_pkg::SEQ_WAIT: begin
                if (i_seq.slot_end) begin
                    nxt_s.st = float_math_pkg::SEQ_IDLE;
                end else if (i_seq.pulse_req &&
                             cfg[float_math_pkg::LED_WIDTH_LSB +: 5] != 5'h0) begin
                    nxt_s.st   = float_math_pkg::SEQ_FIRE;
                    nxt_s.tick = 7'h0;
                    nxt_s.ucnt = 8'(cfg[float_math_pkg::LED_WIDTH_LSB +: 5]);
                    nxt_s.led  = led_of(cfg[float_math_pkg::LED_SEL_LSB +: 2]);
                end
            end
            default: begin
            end
        endcase
        // Samples only count while a float slot is running
        if (i_sample_valid && s_ff.st != float_math_pkg::SEQ_IDLE) begin
            nxt_s.smp_v   = 1'b1;
            nxt_s.smp_sub = sign_of(s_ff.math, s_ff.slot_b, s_ff.idx);
            nxt_s.idx     = s_ff.idx + 2'h1;
            if (s_ff.slot_b && sign_of(s_ff.math, 1'b1, s_ff.idx) &&
                i_adc_data > s_ff.limit && s_ff.bkg_cnt != 16'hffff) begin
                nxt_s.bkg_cnt = s_ff.bkg_cnt + 16'h1;
            end
        end
        // Slot start overrides any pulse in flight
        if (i_seq.start) begin
            nxt_s.slot_b = i_seq.slot_b;
            nxt_s.idx    = 2'h0;
            nxt_s.tick   = 7'h0;
            nxt_s.led    = 3'h0;
            nxt_s.ucnt   = i_seq.slot_b ? s_ff.led_b[7:0] : s_ff.led_a[7:0];
            slot_on = i_seq.slot_b ? (s_ff.en_b == float_math_pkg::FLT_EN_ON)
                                   : (s_ff.en_a == float_math_pkg::FLT_EN_ON);
            nxt_s.st = slot_on ? float_math_pkg::SEQ_DELAY
                               : float_math_pkg::SEQ_IDLE;
        end
        // Register writes
        if (i_reg.wr) begin
            if (i_reg.addr == float_math_pkg::BKG_LIMIT_ADDR) begin
                nxt_s.limit = i_reg.wdata[13:0];
            end else if (i_reg.addr == float_math_pkg::LED_CFG_A_ADDR) begin
                nxt_s.led_a = i_reg.wdata & float_math_pkg::LED_CFG_MASK;
            end else if (i_reg.addr == float_math_pkg::LED_CFG_B_ADDR) begin
                nxt_s.led_b = i_reg.wdata & float_math_pkg::LED_CFG_MASK;
            end else if (i_reg.addr == float_math_pkg::MATH_CTRL_ADDR) begin
                nxt_s.math = i_reg.wdata & float_math_pkg::MATH_MASK;
            end else if (i_reg.addr == float_math_pkg::FLOAT_ENABLE_B_ADDR) begin
                nxt_s.en_b = i_reg.wdata[float_math_pkg::FLT_EN_LSB +: 2];
            end else if (i_reg.addr == float_math_pkg::FLOAT_ENABLE_A_ADDR) begin
                nxt_s.en_a = i_reg.wdata[float_math_pkg::FLT_EN_LSB +: 2];
            end
        end
        // Register reads, unmapped reads as zero
        if (i_reg.rd) begin
            if (i_reg.addr == float_math_pkg::BKG_LIMIT_ADDR) begin
                nxt_s.rd = {2'h0, s_ff.limit};
            end else if (i_reg.addr == float_math_pkg::LED_CFG_A_ADDR) begin
                nxt_s.rd = s_ff.led_a;
            end else if (i_reg.addr == float_math_pkg::LED_CFG_B_ADDR) begin
                nxt_s.rd = s_ff.led_b;
            end else if (i_reg.addr == float_math_pkg::MATH_CTRL_ADDR) begin
                nxt_s.rd = s_ff.math;
            end else if (i_reg.addr == float_math_pkg::FLOAT_ENABLE_B_ADDR) begin
                nxt_s.rd = {1'b0, s_ff.en_b, 13'h0};
            end else if (i_reg.addr == float_math_pkg::FLOAT_ENABLE_A_ADDR) begin
                nxt_s.rd = {1'b0, s_ff.en_a, 13'h0};
            end else if (i_reg.addr == float_math_pkg::BKG_CNT_ADDR) begin
                nxt_s.rd = s_ff.bkg_cnt;
            end else begin
                nxt_s.rd = 16'h0;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            s_ff         <= '0;
            s_ff.st      <= float_math_pkg::SEQ_IDLE;
            s_ff.limit   <= float_math_pkg::BKG_LIMIT_RESET;
            s_ff.led_a   <= float_math_pkg::LED_CFG_RESET;
            s_ff.led_b   <= float_math_pkg::LED_CFG_RESET;
            s_ff.math    <= float_math_pkg::MATH_RESET;
            s_ff.en_a    <= float_math_pkg::FLT_EN_RESET;
            s_ff.en_b    <= float_math_pkg::FLT_EN_RESET;
        end else begin
            s_ff <= nxt_s;
        end
    end

    assign o_rd_data          = s_ff.rd;
    assign o_led_drive        = s_ff.led;
    assign o_sample_valid     = s_ff.smp_v;
    assign o_sample_subtract  = s_ff.smp_sub;
    assign o_integrator_buffer = s_ff.math[float_math_pkg::INT_BUF_BIT];
    assign o_busy             = (s_ff.st != float_math_pkg::SEQ_IDLE);
    assign o_bkg_exceed_count = s_ff.bkg_cnt;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    sequence start_a_on;
        i_seq.start && !i_seq.slot_b && s_ff.en_a == 2'h3;
    endsequence
    sequence start_off;
        i_seq.start && ((!i_seq.slot_b && s_ff.en_a != 2'h3) ||
                        (i_seq.slot_b && s_ff.en_b != 2'h3));
    endsequence

    bkg_count_step_a : assert property (
        (i_sample_valid && o_busy && s_ff.slot_b && !i_seq.start &&
         sign_of(s_ff.math, 1'b1, s_ff.idx) && i_adc_data > s_ff.limit &&
         s_ff.bkg_cnt != 16'hffff)
        |=> o_bkg_exceed_count == $past(o_bkg_exceed_count) + 16'h1)
        else $error("exceed counter did not step");
    bkg_slot_a_a : assert property (
        (o_busy && !s_ff.slot_b) |=> $stable(o_bkg_exceed_count))
        else $error("slot A changed exceed counter");
    led_choice_a : assert property (
        (s_ff.st == float_math_pkg::SEQ_FIRE && !s_ff.slot_b)
        |-> o_led_drive == led_of(s_ff.led_a[15:14]))
        else $error("wrong slot A LED");
    led_choice_b_a : assert property (
        (s_ff.st == float_math_pkg::SEQ_FIRE && s_ff.slot_b)
        |-> o_led_drive == led_of(s_ff.led_b[15:14]))
        else $error("wrong slot B LED");
    pulse_len_a : assert property (
        ($rose(s_ff.st == float_math_pkg::SEQ_FIRE) && !s_ff.slot_b &&
         s_ff.led_a[12:8] == 5'h1 && !i_seq.start)
        |-> ##99 (s_ff.st == float_math_pkg::SEQ_FIRE)
            ##1 (s_ff.st != float_math_pkg::SEQ_FIRE))
        else $error("slot A pulse length wrong");
    pulse_len_b_a : assert property (
        ($rose(s_ff.st == float_math_pkg::SEQ_FIRE) && s_ff.slot_b &&
         s_ff.ucnt == 8'h1 && !i_seq.start)
        |-> ##99 (s_ff.st == float_math_pkg::SEQ_FIRE)
            ##1 (s_ff.st != float_math_pkg::SEQ_FIRE))
        else $error("slot B pulse length wrong");
    first_delay_a : assert property (
        start_a_on |=> s_ff.st == float_math_pkg::SEQ_DELAY &&
                       s_ff.ucnt == $past(s_ff.led_a[7:0]))
        else $error("first pulse delay not loaded");
    sign_pair_a : assert property (
        (i_sample_valid && o_busy && !i_seq.start && s_ff.idx == 2'h1)
        |=> o_sample_subtract == $past(s_ff.slot_b ? s_ff.math[5]
                                                   : s_ff.math[1]))
        else $error("second sample sign wrong");
    sign_third_a : assert property (
        (i_sample_valid && o_busy && !i_seq.start && s_ff.idx == 2'h2)
        |=> o_sample_subtract == $past(s_ff.slot_b ? s_ff.math[11]
                                                   : s_ff.math[9]))
        else $error("third sample sign wrong");
    group_wrap_a : assert property (
        (i_sample_valid && o_busy && !i_seq.start && s_ff.idx == 2'h3)
        |=> s_ff.idx == 2'h0)
        else $error("group of four did not wrap");
    int_buf_a : assert property (
        (i_reg.wr && i_reg.addr == 8'h58)
        |=> o_integrator_buffer == $past(i_reg.wdata[7]))
        else $error("buffer bit not applied");
    enable_gate_a : assert property (
        start_off |=> !o_busy && o_led_drive == 3'h0)
        else $error("float ran while disabled");
endmodule : float_mode_pulse_math_config

`default_nettype wire

/* verif/tb.sv */
// Self-checking bench for the float-mode configuration block
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic                     i_clk = 1'b0;
    logic                     i_nrst;
    float_math_pkg::reg_req_t i_reg;
    float_math_pkg::seq_ctl_t i_seq;
    logic                     i_sample_valid;
    logic [13:0]              i_adc_data;
    logic [15:0]              o_rd_data;
    logic [2:0]               o_led_drive;
    logic                     o_sample_valid;
    logic                     o_sample_subtract;
    logic                     o_integrator_buffer;
    logic                     o_busy;
    logic [15:0]              o_bkg_exceed_count;
    logic [15:0]              rdv;
    logic [15:0]              exp_cnt = 16'h0000;
    int                       num_errors = 0;
    int                       cmp_count = 0;
    int                       cycles = 0;

    float_mode_pulse_math_config u_dut (
        .i_clk               (i_clk),
        .i_nrst              (i_nrst),
        .i_reg               (i_reg),
        .o_rd_data           (o_rd_data),
        .i_seq               (i_seq),
        .i_sample_valid      (i_sample_valid),
        .i_adc_data          (i_adc_data),
        .o_led_drive         (o_led_drive),
        .o_sample_valid      (o_sample_valid),
        .o_sample_subtract   (o_sample_subtract),
        .o_integrator_buffer (o_integrator_buffer),
        .o_busy              (o_busy),
        .o_bkg_exceed_count  (o_bkg_exceed_count)
    );

    always #5 i_clk = ~i_clk;

    // Hang guard, well above the expected run
    always @(posedge i_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            summarize();
        end
    end

    task automatic summarize();
        $display("mismatches %0d compares %0d", num_errors, cmp_count);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    // Inputs move 1 ns after the edge, away from sampling
    task automatic tick();
        @(posedge i_clk);
        #1;
    endtask : tick

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Idle cycle after each strobe so it never rises in the same step
    task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
        i_reg.wr = 1'b1;
        i_reg.addr = a;
        i_reg.wdata = d;
        tick();
        i_reg.wr = 1'b0;
        tick();
    endtask : reg_wr

    task automatic rd_chk(input logic [7:0] a, input logic [15:0] exp);
        i_reg.rd = 1'b1;
        i_reg.addr = a;
        tick();
        rdv = o_rd_data;
        i_reg.rd = 1'b0;
        chk(rdv, exp);
        tick();
    endtask : rd_chk

    task automatic seq_cmd(input logic st, input logic sb, input logic fin);
        i_seq.start = st;
        i_seq.slot_b = sb;
        i_seq.slot_end = fin;
        tick();
        i_seq.start = 1'b0;
        i_seq.slot_end = 1'b0;
    endtask : seq_cmd

    task automatic t_defaults();
        rd_chk(float_math_pkg::LED_CFG_A_ADDR, 16'h0320);
        rd_chk(float_math_pkg::LED_CFG_B_ADDR, 16'h0320);
        rd_chk(float_math_pkg::MATH_CTRL_ADDR, 16'h0000);
        rd_chk(float_math_pkg::BKG_LIMIT_ADDR, 16'h0000);
        rd_chk(float_math_pkg::BKG_CNT_ADDR, 16'h0000);
        chk(16'(o_integrator_buffer), 16'h0000);
        chk(16'(o_busy), 16'h0000);
    endtask : t_defaults

    task automatic t_masks();
        reg_wr(float_math_pkg::LED_CFG_A_ADDR, 16'hffff);
        rd_chk(float_math_pkg::LED_CFG_A_ADDR, 16'hdfff);
        reg_wr(float_math_pkg::LED_CFG_B_ADDR, 16'hffff);
        rd_chk(float_math_pkg::LED_CFG_B_ADDR, 16'hdfff);
        reg_wr(float_math_pkg::MATH_CTRL_ADDR, 16'hffff);
        rd_chk(float_math_pkg::MATH_CTRL_ADDR, 16'h0fe6);
        chk(16'(o_integrator_buffer), 16'h0001);
        reg_wr(float_math_pkg::MATH_CTRL_ADDR, 16'h0000);
        chk(16'(o_integrator_buffer), 16'h0000);
        reg_wr(float_math_pkg::BKG_LIMIT_ADDR, 16'hffff);
        rd_chk(float_math_pkg::BKG_LIMIT_ADDR, 16'h3fff);
        reg_wr(8'h40, 16'hffff);
        rd_chk(8'h40, 16'h0000);
        reg_wr(float_math_pkg::BKG_CNT_ADDR, 16'hffff);
        rd_chk(float_math_pkg::BKG_CNT_ADDR, 16'h0000);
    endtask : t_masks

    // Checks a pulse's first and last cycle and the cycle after it
    task automatic pulse_chk(input logic [2:0] led, input logic [4:0] w);
        chk(16'(o_led_drive), 16'(led));
        repeat (int'(w) * 100 - 1) tick();
        chk(16'(o_led_drive), 16'(led));
        tick();
        chk(16'(o_led_drive), 16'h0000);
    endtask : pulse_chk

    // First pulse after the offset, then a second one on request
    task automatic t_pulse(input logic sb, input logic [1:0] sel,
                           input logic [4:0] w, input logic [7:0] off);
        logic [2:0] led;
        led = (sel == 2'h0) ? 3'h0 : 3'(3'h1 << (sel - 2'h1));
        reg_wr(sb ? float_math_pkg::LED_CFG_B_ADDR
                  : float_math_pkg::LED_CFG_A_ADDR, {sel, 1'b0, w, off});
        seq_cmd(1'b1, sb, 1'b0);
        chk(16'(o_busy), 16'h0001);
        repeat (int'(off) * 100) tick();
        chk(16'(o_led_drive), 16'h0000);
        tick();
        pulse_chk(led, w);
        i_seq.pulse_req = 1'b1;
        tick();
        i_seq.pulse_req = 1'b0;
        pulse_chk(led, w);
        seq_cmd(1'b0, sb, 1'b1);
        chk(16'(o_busy), 16'h0000);
    endtask : t_pulse

    // Reserved enable code must not start the sequencer; idle samples dropped
    task automatic t_disabled();
        reg_wr(float_math_pkg::FLOAT_ENABLE_B_ADDR, 16'h2000);
        seq_cmd(1'b1, 1'b1, 1'b0);
        i_sample_valid = 1'b1;
        tick();
        i_sample_valid = 1'b0;
        chk(16'(o_busy), 16'h0000);
        chk(16'(o_sample_valid), 16'h0000);
        chk(16'(o_led_drive), 16'h0000);
        reg_wr(float_math_pkg::FLOAT_ENABLE_B_ADDR, 16'h6000);
    endtask : t_disabled

    // Nine back-to-back samples wrap the four-sample group twice
    task automatic t_samples(input logic sb, input logic [1:0] c12,
                             input logic [1:0] c34);
        logic [1:0]  code;
        logic        sub;
        logic [13:0] adc;
        reg_wr(float_math_pkg::MATH_CTRL_ADDR, sb ?
               {4'h0, c34, 3'h0, c12, 5'h00} : {6'h00, c34, 5'h00, c12, 1'b0});
        reg_wr(float_math_pkg::BKG_LIMIT_ADDR, 16'h0100);
        seq_cmd(1'b1, sb, 1'b0);
        for (int i = 0; i < 9; i++) begin
            adc = (i % 3 == 0) ? 14'h0100 : (i % 3 == 1) ? 14'h0101 : 14'h0050;
            code = (i % 4 < 2) ? c12 : c34;
            sub = (i % 2 == 0) ? code[1] : code[0];
            if (sb && sub && adc > 14'h0100) begin
                exp_cnt = exp_cnt + 16'h0001;
            end
            i_sample_valid = 1'b1;
            i_adc_data = adc;
            tick();
            chk(16'(o_sample_valid), 16'h0001);
            chk(16'(o_sample_subtract), 16'(sub));
            chk(o_bkg_exceed_count, exp_cnt);
        end
        i_sample_valid = 1'b0;
        rd_chk(float_math_pkg::BKG_CNT_ADDR, exp_cnt);
    endtask : t_samples

    // Reset in mid-run restores every default
    task automatic t_reset();
        i_nrst = 1'b0;
        repeat (2) tick();
        i_nrst = 1'b1;
        exp_cnt = 16'h0000;
        tick();
        t_defaults();
    endtask : t_reset

    initial begin
        i_nrst = 1'b0;
        i_reg = '0;
        i_seq = '0;
        i_sample_valid = 1'b0;
        i_adc_data = 14'h0000;
        repeat (12) @(posedge i_clk);
        #1;
        i_nrst = 1'b1;
        tick();
        t_defaults();
        t_masks();
        reg_wr(float_math_pkg::FLOAT_ENABLE_A_ADDR, 16'hffff);
        rd_chk(float_math_pkg::FLOAT_ENABLE_A_ADDR, 16'h6000);
        reg_wr(float_math_pkg::FLOAT_ENABLE_B_ADDR, 16'h6000);
        for (int s = 0; s < 4; s++) begin
            t_pulse(1'b0, 2'(s), 5'h01, 8'h00);
        end
        t_pulse(1'b1, 2'h3, 5'h01, 8'h00);
        t_pulse(1'b0, 2'h2, 5'h03, 8'h01);
        t_disabled();
        t_pulse(1'b1, 2'h1, 5'h02, 8'h02);
        t_samples(1'b1, 2'b10, 2'b01);
        t_samples(1'b1, 2'b11, 2'b00);
        t_samples(1'b0, 2'b01, 2'b11);
        t_samples(1'b0, 2'b00, 2'b10);
        t_reset();
        summarize();
    end
endmodule : tb
`default_nettype wire
